// ### hw/vdc_pkg.sv
// constants and types shared by the valve drive control block
package vdc_pkg;

   // ***************************************************************
   // time base
   // ***************************************************************
   localparam int CLK_PERIOD_PS = 8000;
   localparam int MS_PS = 1_000_000_000;
   localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
   localparam logic [9:0] MS_PER_S = 10'h3E8;
   localparam logic [3:0] MS_PER_PCT_PER_S = 4'hA;
   localparam logic [5:0] OVER_MS_PER_S = 6'h32;
   localparam logic [18:0] OVER_CAP_MS = 19'h0_EA60;
   localparam logic [22:0] MIN_PULSE_MS = 23'h00_01F4;
   localparam logic [29:0] PCT_DIV = 30'h0000_0064;
   localparam logic [6:0] PCT_FULL = 7'h64;

   // ***************************************************************
   // reversing pause selection and durations in ms
   // ***************************************************************
   localparam logic [2:0] REV_NONE = 3'h0;
   localparam logic [2:0] REV_100 = 3'h1;
   localparam logic [2:0] REV_300 = 3'h2;
   localparam logic [2:0] REV_500 = 3'h3;
   localparam logic [2:0] REV_700 = 3'h4;
   localparam logic [2:0] REV_1000 = 3'h5;
   localparam logic [18:0] REV_100_MS = 19'h0_0064;
   localparam logic [18:0] REV_300_MS = 19'h0_012C;
   localparam logic [18:0] REV_500_MS = 19'h0_01F4;
   localparam logic [18:0] REV_700_MS = 19'h0_02BC;
   localparam logic [18:0] REV_1000_MS = 19'h0_03E8;

   // ***************************************************************
   // heating/cooling state after recovery
   // ***************************************************************
   localparam logic [1:0] HC_KEEP = 2'h0;
   localparam logic [1:0] HC_HEAT = 2'h1;
   localparam logic [1:0] HC_COOL = 2'h2;

   // ***************************************************************
   // reset values and counter maximum
   // ***************************************************************
   localparam logic [6:0] POS_RESET = 7'h00;
   localparam logic [15:0] ADJ_CNT_RESET = 16'h0000;
   localparam logic [15:0] ADJ_CNT_MAX = 16'hFFFF;

   typedef enum logic [1:0] {
      JOB_NORMAL,
      JOB_ADJUST,
      JOB_REFERENCE
   } vdc_job_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PAUSE,
      ST_MOVE,
      ST_OVER
   } vdc_state_type;

endpackage

// ### hw/vdc_ms_tick.sv
// millisecond tick generator for the valve drive control block
`timescale 1ns/1ps
module vdc_ms_tick #(
   parameter int MS_CYCLES = 125000
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // one-cycle pulse every millisecond
   output logic tick
);
   import vdc_pkg::*;

   logic [19:0] cnt_reg;
   logic [19:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   always_comb begin
      if (cnt_reg >= 20'(MS_CYCLES - 1)) begin
         cnt_next = 20'h0_0000;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 20'h0_0001;
         tick_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 20'h0_0000;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule

// ### hw/vdc_valve_drive_control.sv
// valve drive control: three-point motor drive or pwm drive of one heating valve
`timescale 1ns/1ps
// Summary of operation
// - on bus recovery, heating/cooling state is kept, forced heating or forced cooling.
// - three-point reversal waits none, 100, 300, 500, 700 or 1000 ms.
// - three-point drive stops on bus failure, valve stays where it is.
// - after recovery the valve keeps position or goes to a configured percentage.
// - opening run time 10 to 6000 s sets opening travel timing.
// - with adjustment enabled, a zero command becomes an adjustment run.
// - adjustment overtravels closed by 5 % of run time, max one minute, uninterruptible.
// - adjustment counter counts one per motor stop after real movement.
// - counter above its limit on a closing move starts an adjustment run.
// - adjustment waits while priority is active, aborts on priority except in reversing pause or overtravel.
// - no real movement leaves the adjustment counter untouched.
// - reference run after reset, bus reset, version change or changed run time.
// - reference run is uninterruptible, overtravels, then returns and zeroes the counter.
// - adjustment limit is configurable from 1 to 65535 operations.
// - no manual adjustment trigger exists; only counter limit or zero command.
// - pwm energising opens a normally-closed valve, closes a normally-open one.
// - pwm output de-energises on bus failure.
// - pwm period is configurable from 10 to 6000 s.
// - pwm on and off pulses are never shorter than 0.5 s.
// - closing run time 10 to 6000 s sets closing travel timing.
module vdc_valve_drive_control #(
   parameter int MS_CYCLES = vdc_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // bus supply state from the pin, high while bus voltage is present
   input wire logic bus_ok,
   // control value and heating/cooling commands
   input wire logic cv_valid,
   input wire logic [6:0] cv_value,
   input wire logic hc_set_valid,
   input wire logic hc_set_cool,
   // higher-priority function
   input wire logic prio_active,
   input wire logic [6:0] prio_pos,
   // reference request: version change, unconfigured reset, changed run time
   input wire logic ref_req,
   // configuration
   input wire logic cfg_mode_pwm,
   input wire logic cfg_valve_nopen,
   input wire logic [2:0] cfg_rev_sel,
   input wire logic [12:0] cfg_run_open_s,
   input wire logic [12:0] cfg_run_close_s,
   input wire logic [12:0] cfg_pwm_period_s,
   input wire logic cfg_recov_select,
   input wire logic [6:0] cfg_recov_pos,
   input wire logic [1:0] cfg_hc_recov,
   input wire logic cfg_adj_en,
   input wire logic [15:0] cfg_adj_limit,
   // valve drive outputs
   output logic drv_open,
   output logic drv_close,
   output logic pwm_out,
   // status
   output logic hc_cool,
   output logic [6:0] valve_pos,
   output logic [15:0] adj_count,
   output logic adjust_busy,
   output logic reference_busy
);
   import vdc_pkg::*;

   // ***************************************************************
   // bus supply synchroniser and time base
   // ***************************************************************
   logic bus_s1_reg;
   logic bus_s2_reg;
   logic bus_s3_reg;
   logic bus_q_reg;
   logic bus_q_next;
   logic tick;

   // state changes only when the last two stages agree, filtering a glitch
   always_comb begin
      bus_q_next = (bus_s2_reg == bus_s3_reg) ? bus_s3_reg : bus_q_reg;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_s1_reg <= 1'b0;
         bus_s2_reg <= 1'b0;
         bus_s3_reg <= 1'b0;
         bus_q_reg <= 1'b0;
      end else begin
         bus_s1_reg <= bus_ok;
         bus_s2_reg <= bus_s1_reg;
         bus_s3_reg <= bus_s2_reg;
         bus_q_reg <= bus_q_next;
      end
   end

   vdc_ms_tick #(
      .MS_CYCLES(MS_CYCLES)
   ) u_tick (
      .clk(clk),
      .nrst(nrst),
      .tick(tick)
   );

   // ***************************************************************
   // derived timing
   // ***************************************************************
   logic [18:0] step_open_ms;
   logic [18:0] step_close_ms;
   logic [18:0] over_raw_ms;
   logic [18:0] over_ms;
   logic [18:0] rev_ms;
   logic [22:0] period_ms;
   logic [6:0] duty;
   logic [29:0] on_prod;
   logic [22:0] on_raw_ms;
   logic [22:0] on_ms;

   // one percent of travel lasts run time * 10 ms
   assign step_open_ms = 19'(cfg_run_open_s) * 19'(MS_PER_PCT_PER_S);
   assign step_close_ms = 19'(cfg_run_close_s) * 19'(MS_PER_PCT_PER_S);
   assign over_raw_ms = 19'(cfg_run_close_s) * 19'(OVER_MS_PER_S);
   assign over_ms = (over_raw_ms > OVER_CAP_MS) ? OVER_CAP_MS : over_raw_ms;

   always_comb begin
      case (cfg_rev_sel)
         REV_NONE: rev_ms = 19'h0_0000;
         REV_100: rev_ms = REV_100_MS;
         REV_300: rev_ms = REV_300_MS;
         REV_500: rev_ms = REV_500_MS;
         REV_700: rev_ms = REV_700_MS;
         REV_1000: rev_ms = REV_1000_MS;
         default: rev_ms = REV_300_MS;
      endcase
   end

   assign period_ms = 23'(cfg_pwm_period_s) * 23'(MS_PER_S);
   assign on_prod = 30'(period_ms) * 30'(duty);
   assign on_raw_ms = 23'(on_prod / PCT_DIV);

   // a pulse too short for the actuator is stretched, or the on time cut so the gap lasts MIN_PULSE_MS
   always_comb begin
      if (on_raw_ms != 23'h00_0000 && on_raw_ms < MIN_PULSE_MS) begin
         on_ms = MIN_PULSE_MS;
      end else if (on_raw_ms != period_ms && (period_ms - on_raw_ms) < MIN_PULSE_MS) begin
         on_ms = period_ms - MIN_PULSE_MS;
      end else begin
         on_ms = on_raw_ms;
      end
   end

   // ***************************************************************
   // drive state machine
   // ***************************************************************
   vdc_state_type st_reg, st_next;
   vdc_job_type job_reg, job_next;
   logic [6:0] pos_reg, pos_next;
   logic [6:0] cmd_reg, cmd_next;
   logic [18:0] tmr_reg, tmr_next;
   logic [22:0] phase_reg, phase_next;
   logic [15:0] cnt_reg, cnt_next;
   logic close_reg, close_next;
   logic moved_reg, moved_next;
   logic adj_pend_reg, adj_pend_next;
   logic ref_pend_reg, ref_pend_next;
   logic hc_reg, hc_next;
   logic prio_q_reg;
   logic open_reg, open_next;
   logic shut_reg, shut_next;
   logic pwm_reg, pwm_next;
   logic [6:0] tgt;
   logic [6:0] goal;
   logic prio_event;
   logic bus_rise;
   logic bus_fall;
   logic want_close;
   logic stop;

   assign tgt = prio_active ? prio_pos : cmd_reg;
   assign goal = (job_reg == JOB_NORMAL) ? tgt : POS_RESET;
   assign prio_event = prio_active & ~prio_q_reg;
   assign bus_rise = bus_q_next & ~bus_q_reg;
   assign bus_fall = bus_q_reg & ~bus_q_next;
   assign duty = cfg_valve_nopen ? (PCT_FULL - cmd_reg) : cmd_reg;

   always_comb begin
      st_next = st_reg;
      job_next = job_reg;
      pos_next = pos_reg;
      cmd_next = cmd_reg;
      tmr_next = tmr_reg;
      phase_next = phase_reg;
      cnt_next = cnt_reg;
      close_next = close_reg;
      moved_next = moved_reg;
      adj_pend_next = adj_pend_reg;
      ref_pend_next = ref_pend_reg;
      hc_next = hc_reg;
      want_close = 1'b0;
      stop = 1'b0;

      if (hc_set_valid) begin
         hc_next = hc_set_cool;
      end
      if (cv_valid && bus_q_reg) begin
         cmd_next = (cv_value > PCT_FULL) ? PCT_FULL : cv_value;
         if (cv_value == 7'h00 && cfg_adj_en && !cfg_mode_pwm) begin
            adj_pend_next = 1'b1;
         end
      end
      if (ref_req) begin
         ref_pend_next = 1'b1;
      end
      if (bus_rise) begin
         ref_pend_next = 1'b1;
         if (cfg_recov_select) begin
            cmd_next = cfg_recov_pos;
         end
         case (cfg_hc_recov)
            HC_HEAT: hc_next = 1'b0;
            HC_COOL: hc_next = 1'b1;
            default: hc_next = hc_reg;
         endcase
      end

      // pwm phase runs only while the bus is up
      if (!bus_q_reg || !cfg_mode_pwm) begin
         phase_next = 23'h00_0000;
      end else if (tick) begin
         phase_next = (phase_reg + 23'h00_0001 >= period_ms) ? 23'h00_0000 :
                      phase_reg + 23'h00_0001;
      end

      case (st_reg)
         ST_IDLE: begin
            if (bus_q_reg && !cfg_mode_pwm) begin
               if (ref_pend_reg) begin
                  ref_pend_next = ref_req;
                  job_next = JOB_REFERENCE;
                  want_close = 1'b1;
               end else if (adj_pend_reg && !prio_active) begin
                  adj_pend_next = 1'b0;
                  job_next = JOB_ADJUST;
                  want_close = 1'b1;
               end else if (tgt != pos_reg) begin
                  want_close = tgt < pos_reg;
                  job_next = JOB_NORMAL;
                  if (want_close && cfg_adj_en && cnt_reg > cfg_adj_limit) begin
                     if (prio_active) begin
                        adj_pend_next = 1'b1;
                     end else begin
                        job_next = JOB_ADJUST;
                     end
                  end
               end
               if (ref_pend_reg || (adj_pend_reg && !prio_active) || tgt != pos_reg) begin
                  close_next = want_close;
                  moved_next = 1'b0;
                  tmr_next = want_close ? step_close_ms : step_open_ms;
                  if (want_close != close_reg && rev_ms != 19'h0_0000) begin
                     st_next = ST_PAUSE;
                     tmr_next = rev_ms;
                  end else begin
                     st_next = ST_MOVE;
                  end
               end
            end
         end
         ST_PAUSE: begin
            if (tick) begin
               tmr_next = tmr_reg - 19'h0_0001;
               if (tmr_reg <= 19'h0_0001) begin
                  st_next = ST_MOVE;
                  tmr_next = close_reg ? step_close_ms : step_open_ms;
               end
            end
         end
         ST_MOVE: begin
            if (pos_reg == goal) begin
               if (job_reg == JOB_NORMAL) begin
                  stop = 1'b1;
               end else begin
                  st_next = ST_OVER;
                  tmr_next = over_ms;
               end
            end else if (job_reg == JOB_NORMAL && (close_reg != (goal < pos_reg))) begin
               stop = 1'b1;
            end else if (job_reg == JOB_ADJUST && prio_event) begin
               job_next = JOB_NORMAL;
               stop = 1'b1;
            end else if (tick) begin
               tmr_next = tmr_reg - 19'h0_0001;
               if (tmr_reg <= 19'h0_0001) begin
                  pos_next = close_reg ? pos_reg - 7'h01 : pos_reg + 7'h01;
                  moved_next = 1'b1;
                  tmr_next = close_reg ? step_close_ms : step_open_ms;
               end
            end
         end
         ST_OVER: begin
            // no abort path here: overtravel completes unless bus failure or pwm mode below ends it
            if (tick) begin
               tmr_next = tmr_reg - 19'h0_0001;
               if (tmr_reg <= 19'h0_0001) begin
                  st_next = ST_IDLE;
                  job_next = JOB_NORMAL;
                  pos_next = POS_RESET;
                  cnt_next = ADJ_CNT_RESET;
               end
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase

      if (stop) begin
         st_next = ST_IDLE;
         if (moved_reg && cnt_reg != ADJ_CNT_MAX) begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end

      // bus failure halts any run where it stands
      if (bus_fall) begin
         st_next = ST_IDLE;
         job_next = JOB_NORMAL;
         if (st_reg == ST_MOVE && moved_reg && cnt_reg != ADJ_CNT_MAX) begin
            cnt_next = cnt_reg + 16'h0001;
         end
      end
      if (cfg_mode_pwm) begin
         st_next = ST_IDLE;
         job_next = JOB_NORMAL;
         ref_pend_next = 1'b0;
         adj_pend_next = 1'b0;
      end

      open_next = bus_q_next && st_next == ST_MOVE && !close_next;
      shut_next = bus_q_next && (st_next == ST_OVER || (st_next == ST_MOVE && close_next));
      pwm_next = bus_q_next && cfg_mode_pwm && (phase_next < on_ms);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= ST_IDLE;
         job_reg <= JOB_NORMAL;
         pos_reg <= POS_RESET;
         cmd_reg <= POS_RESET;
         tmr_reg <= 19'h0_0000;
         phase_reg <= 23'h00_0000;
         cnt_reg <= ADJ_CNT_RESET;
         close_reg <= 1'b1;
         moved_reg <= 1'b0;
         adj_pend_reg <= 1'b0;
         ref_pend_reg <= 1'b1;
         hc_reg <= 1'b0;
         prio_q_reg <= 1'b0;
         open_reg <= 1'b0;
         shut_reg <= 1'b0;
         pwm_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         job_reg <= job_next;
         pos_reg <= pos_next;
         cmd_reg <= cmd_next;
         tmr_reg <= tmr_next;
         phase_reg <= phase_next;
         cnt_reg <= cnt_next;
         close_reg <= close_next;
         moved_reg <= moved_next;
         adj_pend_reg <= adj_pend_next;
         ref_pend_reg <= ref_pend_next;
         hc_reg <= hc_next;
         prio_q_reg <= prio_active;
         open_reg <= open_next;
         shut_reg <= shut_next;
         pwm_reg <= pwm_next;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign drv_open = open_reg;
   assign drv_close = shut_reg;
   assign pwm_out = pwm_reg;
   assign hc_cool = hc_reg;
   assign valve_pos = cfg_mode_pwm ? cmd_reg : pos_reg;
   assign adj_count = cnt_reg;
   assign adjust_busy = (job_reg == JOB_ADJUST);
   assign reference_busy = (job_reg == JOB_REFERENCE);
endmodule

// ### tb/vdc_actuator_model.sv
// behavioural valve actuator on the far side of the drive outputs
`timescale 1ns/1ps
module vdc_actuator_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // drive from the controller
   input wire logic drv_open,
   input wire logic drv_close,
   input wire logic pwm_out,
   input wire logic cfg_valve_nopen,
   // valve state seen by the bench
   output logic act_open,
   output logic act_fault
);
   logic fault_reg;
   logic fault_next;
   // energising opens a normally-closed valve and closes a normally-open one
   assign act_open = pwm_out ^ cfg_valve_nopen;
   // both windings at once would stall a real motor, so it latches
   always_comb begin
      fault_next = fault_reg | (drv_open & drv_close);
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= fault_next;
      end
   end
   assign act_fault = fault_reg;
endmodule

// ### tb/vdc_checker.sv
// concurrent checks on the ports of the valve drive control block
`timescale 1ns/1ps
module vdc_checker (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // watched inputs
   input wire logic bus_ok,
   input wire logic cfg_mode_pwm,
   // watched outputs
   input wire logic drv_open,
   input wire logic drv_close,
   input wire logic pwm_out,
   input wire logic [6:0] valve_pos,
   input wire logic [15:0] adj_count,
   input wire logic adjust_busy,
   input wire logic reference_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic moving = drv_open | drv_close;
   // ***************************************************************
   // assertions
   // ***************************************************************
   a_drive_exclusive:
      assert property (!(drv_open && drv_close))
      else $error("open and close driven together");
   a_bus_fail_stop:
      assert property (!bus_ok [*8] |-> !moving && !pwm_out)
      else $error("output still driven after bus loss");
   a_ref_only_close:
      assert property (reference_busy |-> !drv_open)
      else $error("opening during reference run");
   a_adj_only_close:
      assert property (adjust_busy |-> !drv_open)
      else $error("opening during adjustment run");
   a_ref_end_zero:
      assert property ($fell(reference_busy) |-> adj_count == 16'h0000 && valve_pos == 7'h00)
      else $error("reference run ended without zeroing");
   a_count_step:
      assert property (!$stable(adj_count) |->
         adj_count == $past(adj_count) + 16'h0001 || adj_count == 16'h0000)
      else $error("adjustment counter jumped");
   a_count_needs_move:
      assert property (!$stable(adj_count) && adj_count != 16'h0000 |->
         $past(moving, 1) || $past(moving, 2))
      else $error("counter moved without drive");
   a_pos_one_step:
      assert property (!cfg_mode_pwm && !$past(cfg_mode_pwm) && !$stable(valve_pos) |->
         valve_pos == $past(valve_pos) + 7'h01 || valve_pos == $past(valve_pos) - 7'h01)
      else $error("tracked position jumped");
   // ***************************************************************
   // covers
   // ***************************************************************
   c_reference: cover property ($fell(reference_busy));
   c_adjust: cover property ($fell(adjust_busy));
   c_pwm_pulse: cover property ($fell(pwm_out));
endmodule
bind vdc_valve_drive_control vdc_checker chk (
   .clk(clk),
   .nrst(nrst),
   .bus_ok(bus_ok),
   .cfg_mode_pwm(cfg_mode_pwm),
   .drv_open(drv_open),
   .drv_close(drv_close),
   .pwm_out(pwm_out),
   .valve_pos(valve_pos),
   .adj_count(adj_count),
   .adjust_busy(adjust_busy),
   .reference_busy(reference_busy)
);

// ### tb/valve_drive_control_bench.sv
// self-checking bench for the valve drive control block
`timescale 1ns/1ps
module valve_drive_control_bench;
   import vdc_pkg::*;
   // a millisecond of 10 clocks keeps the one- and two-percent strokes inside the run
   localparam int MSC = 10;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic bus_ok = 1'b0;
   logic cv_valid = 1'b0;
   logic [6:0] cv_value = 7'h00;
   logic hc_set_valid = 1'b0;
   logic hc_set_cool = 1'b0;
   logic cfg_mode_pwm = 1'b0;
   logic cfg_valve_nopen = 1'b0;
   logic [2:0] cfg_rev_sel = REV_300;
   logic [12:0] cfg_run_open_s = 13'h000A;
   logic cfg_recov_select = 1'b0;
   logic prio_active = 1'b0;
   logic ref_req = 1'b0;
   logic cfg_adj_en = 1'b1;
   logic [1:0] cfg_hc_recov = HC_COOL;
   logic drv_open, drv_close, pwm_out, hc_cool, adjust_busy, reference_busy;
   logic act_open, act_fault;
   logic [6:0] valve_pos;
   logic [15:0] adj_count;
   int num_errors = 0;
   int samples_checked = 0;
   int n;
   vdc_valve_drive_control #(.MS_CYCLES(MSC)) dut (.clk(clk), .nrst(nrst), .bus_ok(bus_ok),
      .cv_valid(cv_valid), .cv_value(cv_value), .hc_set_valid(hc_set_valid),
      .hc_set_cool(hc_set_cool), .prio_active(prio_active), .prio_pos(7'h00),
      .ref_req(ref_req),
      .cfg_mode_pwm(cfg_mode_pwm), .cfg_valve_nopen(cfg_valve_nopen),
      .cfg_rev_sel(cfg_rev_sel), .cfg_run_open_s(cfg_run_open_s),
      .cfg_run_close_s(13'h0014), .cfg_pwm_period_s(13'h000A),
      .cfg_recov_select(cfg_recov_select), .cfg_recov_pos(7'h01),
      .cfg_hc_recov(cfg_hc_recov), .cfg_adj_en(cfg_adj_en), .cfg_adj_limit(16'h0064),
      .drv_open(drv_open),
      .drv_close(drv_close), .pwm_out(pwm_out), .hc_cool(hc_cool), .valve_pos(valve_pos),
      .adj_count(adj_count), .adjust_busy(adjust_busy), .reference_busy(reference_busy));
   vdc_actuator_model act (.clk(clk), .nrst(nrst), .drv_open(drv_open),
      .drv_close(drv_close), .pwm_out(pwm_out), .cfg_valve_nopen(cfg_valve_nopen),
      .act_open(act_open), .act_fault(act_fault));
   initial begin
      forever #4 clk = ~clk;
   end
   // ***************************************************************
   // access and compare tasks
   // ***************************************************************
   function automatic logic pick(input int sel);
      case (sel)
         0: pick = drv_open;
         1: pick = drv_close;
         2: pick = pwm_out;
         3: pick = reference_busy;
         default: pick = adjust_busy;
      endcase
   endfunction
   task automatic cycles(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // counts cycles until the chosen output reaches lvl, bounded by lim
   task automatic wait_sig(input int sel, input logic lvl, input int lim, output int k);
      k = 0;
      while (pick(sel) !== lvl && k < lim) begin
         cycles(1);
         k++;
      end
   endtask
   task automatic pulse_cv(input logic [6:0] v);
      @(posedge clk);
      cv_valid <= 1'b1;
      cv_value <= v;
      @(posedge clk);
      cv_valid <= 1'b0;
   endtask
   task automatic check_bit(input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: expected %0h got %0h", $time, exp, got);
      end
   endtask
   task automatic check_word(input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: expected %0h got %0h", $time, exp, got);
      end
   endtask
   // a span in clocks, allowing for the free-running millisecond divider
   task automatic check_span(input int exp, input int got);
      samples_checked++;
      if (got < exp - 12 || got > exp + 20) begin
         num_errors++;
         $display("CHECK FAILED at %0t: expected %0h got %0h", $time, exp, got);
      end
   endtask
   // measures a three-point move: pause then travel
   task automatic move(input int sel, input int pause, input int travel);
      wait_sig(sel, 1'b1, pause + 100, n);
      check_span(pause, n);
      wait_sig(sel, 1'b0, travel + 100, n);
      check_span(travel, n);
      cycles(3);
   endtask
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #(100000 * 8);
      num_errors++;
      summarize();
   end
   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      bus_ok <= 1'b1;
      wait_sig(3, 1'b1, 50, n);
      check_bit(1'b1, reference_busy);
      wait_sig(1, 1'b0, 12000, n);
      check_span(10000, n);
      check_word(16'h0000, adj_count);
      $display("test reference done");
      pulse_cv(7'h02);
      move(0, 3000, 2000);
      check_word(16'h0002, {9'h000, valve_pos});
      check_word(16'h0001, adj_count);
      pulse_cv(7'h01);
      move(1, 3000, 2000);
      check_word(16'h0002, adj_count);
      $display("test three point done");
      pulse_cv(7'h00);
      cycles(3);
      check_bit(1'b1, adjust_busy);
      wait_sig(1, 1'b0, 13000, n);
      check_span(12000, n);
      cycles(3);
      check_word(16'h0000, adj_count);
      check_bit(1'b0, adjust_busy);
      $display("test adjustment done");
      @(posedge clk);
      hc_set_valid <= 1'b1;
      @(posedge clk);
      hc_set_valid <= 1'b0;
      pulse_cv(7'h02);
      wait_sig(0, 1'b1, 3100, n);
      cycles(500);
      bus_ok <= 1'b0;
      cycles(10);
      check_bit(1'b0, drv_open);
      check_word(16'h0000, adj_count);
      @(posedge clk);
      cfg_recov_select <= 1'b1;
      cfg_rev_sel <= REV_500;
      cfg_run_open_s <= 13'h0014;
      cycles(20);
      bus_ok <= 1'b1;
      wait_sig(3, 1'b1, 50, n);
      check_bit(1'b1, hc_cool);
      wait_sig(3, 1'b0, 16000, n);
      check_span(15000, n);
      move(0, 5000, 2000);
      check_word(16'h0001, {9'h000, valve_pos});
      $display("test bus recovery done");
      @(posedge clk);
      ref_req <= 1'b1;
      @(posedge clk);
      ref_req <= 1'b0;
      cycles(3);
      check_bit(1'b1, reference_busy);
      wait_sig(3, 1'b0, 18000, n);
      check_span(17000, n);
      check_word(16'h0000, adj_count);
      $display("test reference request done");
      @(posedge clk);
      cfg_mode_pwm <= 1'b1;
      pulse_cv(7'h01);
      wait_sig(2, 1'b1, 50, n);
      wait_sig(2, 1'b0, 8000, n);
      check_span(5000, n);
      @(posedge clk);
      cfg_valve_nopen <= 1'b1;
      pulse_cv(7'h64);
      cycles(3);
      check_bit(1'b0, pwm_out);
      check_bit(1'b1, act_open);
      @(posedge clk);
      cfg_valve_nopen <= 1'b0;
      cycles(3);
      check_bit(1'b1, pwm_out);
      bus_ok <= 1'b0;
      cycles(10);
      check_bit(1'b0, pwm_out);
      check_bit(1'b0, act_open);
      check_bit(1'b0, act_fault);
      $display("test pwm done");
      summarize();
   end
endmodule
